//--- hdl/lpc_pkg.sv
// lpc_pkg: constants for the line printer channel controller.
// assumes a 100 MHz mclk and a 12-bit channel code bus.
package lpc_pkg;
    localparam int CLK_NS      = 10;
    localparam int CLR_TIME_US = 100;
    localparam int CLR_CYC     = (CLR_TIME_US * 1000) / CLK_NS;
    localparam int LINE_MAX    = 136;

    // apb byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_FRAME  = 8'h08;
    localparam logic [1:0] CTRL_RST   = 2'h0;

    // status word bit positions
    localparam int ST_CONN  = 0;
    localparam int ST_RSV   = 1;
    localparam int ST_READY = 2;
    localparam int ST_TPE   = 3;
    localparam int ST_CH    = 4;
    localparam int ST_LOWP  = 5;
    localparam int ST_STATE = 8;

    // function codes (octal in comments)
    localparam logic [11:0] FN_RELEASE = 12'h000; // 0000
    localparam logic [11:0] FN_DISCON  = 12'h020; // 0040
    localparam logic [11:0] FN_EJECT   = 12'h004; // 0004
    localparam logic [11:0] FN_POST0   = 12'h008; // 0010 + level
    localparam logic [11:0] FN_PRE0    = 12'h018; // 0030 + level
    localparam logic [11:0] FN_INT_EOP = 12'h010; // 0020
    localparam logic [11:0] FN_INT_CLR = 12'h011; // 0021
    localparam logic [3:0]  LVL_NONE   = 4'h0;
    localparam logic [3:0]  LVL_EIGHT  = 4'h8;

    typedef enum logic [2:0] {
        LPC_IDLE  = 3'h0,
        LPC_LOAD  = 3'h1,
        LPC_PRE   = 3'h3,
        LPC_PRINT = 3'h2,
        LPC_POST  = 3'h6,
        LPC_HALT  = 3'h7
    } lpc_state_t;
endpackage

//--- hdl/lpc_ctrl.sv
// lpc_ctrl: channel-side controller for a buffered line printer.
// assumes channel strobes on mclk; panel and printer pins are asynchronous.
//
// Decided for this implementation: the APB register port and the placing of the registers.
module lpc_ctrl
    import lpc_pkg::*;
#(
    parameter int CLR_CYCLES = CLR_CYC
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ch_id,
    input  wire logic        ch_connect,
    input  wire logic        ch_function,
    input  wire logic        ch_clear,
    input  wire logic        ch_write,
    input  wire logic        ch_last,
    input  wire logic        ch_par_err,
    input  wire logic [11:0] ch_code,
    input  wire logic        ext_mclr,
    output logic             ch_reply,
    output logic             ch_reject,
    output logic             ch_perr,
    output logic             ch_wr_ready,
    output logic [7:0]       irq,
    output logic             connected,
    output logic             reserved,
    output logic             conn_chan,
    output logic             ready,
    output logic             tpe_lamp,
    input  wire logic [2:0]  eq_sw,
    input  wire logic        sw_start,
    input  wire logic        sw_stop,
    input  wire logic        sw_space,
    input  wire logic        sw_eject,
    input  wire logic        sw_par_ovr,
    input  wire logic        sw_err_ovr,
    input  wire logic        low_paper,
    input  wire logic        print_err,
    input  wire logic        prt_done,
    input  wire logic        step_ack,
    input  wire logic [7:0]  tape_hole,
    output logic             pm_we,
    output logic [7:0]       pm_addr,
    output logic [11:0]      pm_data,
    output logic             prt_go,
    output logic             paper_step
);
    localparam int SW = 21;

    // the clear window must span at least two cycles and fit the counter
    if (CLR_CYCLES < 2 || CLR_CYCLES > 65535) begin : g_bad_clr
        $error("CLR_CYCLES out of range");
    end

    function automatic logic hole_at(input logic [7:0] h,
                                     input logic [3:0] lvl);
        hole_at = (lvl == LVL_NONE) ? 1'b1 : h[3'(lvl - 4'h1)];
    endfunction

    // three flops per pin; stage b feeds logic, stage c only the edge detects
    logic [SW-1:0] sy_a_q, sy_b_q, sy_c_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sy_a_q <= '0;
            sy_b_q <= '0;
            sy_c_q <= '0;
        end else begin
            sy_a_q <= {eq_sw, sw_start, sw_stop, sw_space, sw_eject,
                       sw_par_ovr, sw_err_ovr, low_paper, print_err,
                       prt_done, step_ack, tape_hole};
            sy_b_q <= sy_a_q;
            sy_c_q <= sy_b_q;
        end
    end
    logic [2:0] eq_n;
    logic [7:0] holes;
    logic       start_p, stop_p, space_p, eject_p, done_p, ack_p;
    logic       par_ovr, err_ovr, lowp, perr_in;
    assign eq_n    = sy_b_q[20:18];
    assign start_p = sy_b_q[17] & ~sy_c_q[17];
    assign stop_p  = sy_b_q[16] & ~sy_c_q[16];
    assign space_p = sy_b_q[15] & ~sy_c_q[15];
    assign eject_p = sy_b_q[14] & ~sy_c_q[14];
    assign par_ovr = sy_b_q[13];
    assign err_ovr = sy_b_q[12];
    assign lowp    = sy_b_q[11];
    assign perr_in = sy_b_q[10];
    assign done_p  = sy_b_q[9] & ~sy_c_q[9];
    assign ack_p   = sy_b_q[8] & ~sy_c_q[8];
    assign holes   = sy_b_q[7:0];

    // apb slave, zero wait states
    logic [1:0] ctrl_q, ctrl_d;
    logic       wr_en, map_ok;
    assign pready  = 1'b1;
    assign map_ok  = paddr == OFS_STATUS || paddr == OFS_CTRL ||
                     paddr == OFS_FRAME;
    assign pslverr = psel & penable & ~map_ok;
    assign wr_en   = psel & penable & pwrite & (paddr == OFS_CTRL);
    always_comb begin
        ctrl_d = wr_en ? pwdata[1:0] : ctrl_q;
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) ctrl_q <= CTRL_RST;
        else         ctrl_q <= ctrl_d;
    end
    // ctrl bit0: general error override fitted; bit1: irq lines gated off
    logic gen_ovr_fit, irq_off;
    assign gen_ovr_fit = ctrl_q[0];
    assign irq_off     = ctrl_q[1];

    lpc_state_t st_q, st_d;
    logic        conn_q, conn_d, rsv_q, rsv_d, cch_q, cch_d;
    logic        tpe_q, tpe_d, stop_seen_q, stop_seen_d;
    logic        online_q, online_d, lph_q, lph_d, credit_q, credit_d;
    logic        exhaust_q, exhaust_d, eopsel_q, eopsel_d;
    logic        eop_q, eop_d, perr_line_q, perr_line_d;
    logic [3:0]  post_q, post_d, pre_q, pre_d, sp_q, sp_d;
    logic        spw_q, spw_d, step_q, step_d, go_q, go_d;
    logic [7:0]  frame_q, frame_d, addr_q, addr_d;
    logic        we_q, we_d, rep_q, rep_d, rej_q, rej_d, pe_q, pe_d;
    logic [11:0] dat_q, dat_d;
    logic [15:0] clr_q, clr_d;
    logic        own, busy_clr, mclr, stopping, line_end;

    assign own      = conn_q & (cch_q == ch_id);
    assign busy_clr = clr_q != 16'h0000;
    assign mclr     = ext_mclr;
    assign stopping = ~online_q | lph_q;
    // line ends only on an accepted char, also a one-char line from idle
    assign line_end = ch_write & ch_wr_ready &
                      (ch_last | addr_q == 8'(LINE_MAX - 1));
    // loading already under way may finish while stopped
    assign ch_wr_ready = own & ~busy_clr &
                         (st_q == LPC_LOAD || (st_q == LPC_IDLE & ~stopping));

    always_comb begin
        st_d = st_q; conn_d = conn_q; rsv_d = rsv_q; cch_d = cch_q;
        tpe_d = tpe_q; stop_seen_d = stop_seen_q; online_d = online_q;
        lph_d = lph_q; credit_d = credit_q; exhaust_d = exhaust_q;
        eopsel_d = eopsel_q; eop_d = eop_q; perr_line_d = perr_line_q;
        post_d = post_q; pre_d = pre_q; sp_d = sp_q; spw_d = spw_q;
        frame_d = frame_q; addr_d = addr_q; dat_d = dat_q;
        clr_d = busy_clr ? clr_q - 16'h0001 : clr_q;
        we_d = 1'b0; rep_d = 1'b0; rej_d = 1'b0; pe_d = 1'b0;
        step_d = 1'b0; go_d = 1'b0;
        if (start_p) online_d = 1'b1;
        if (stop_p) begin
            online_d = 1'b0;
            stop_seen_d = 1'b1;
        end
        if (start_p & stop_seen_q) stop_seen_d = 1'b0;
        // stop then start clears the parity flag
        if (start_p & stop_seen_q) tpe_d = 1'b0;
        // connect compares equipment field with the switch
        if (ch_connect & ~busy_clr) begin
            if (ch_par_err) begin
                tpe_d = 1'b1;
            end else if (ch_code[11:9] == eq_n) begin
                conn_d = 1'b1; rsv_d = 1'b1; cch_d = ch_id; rep_d = 1'b1;
            end else if (own) begin
                conn_d = 1'b0;
            end
        end
        if (ch_function & own & ~busy_clr) begin
            if (ch_par_err) begin
                tpe_d = 1'b1;
                pe_d = 1'b1;
            end else begin
                rep_d = 1'b1;
                // release drops only the issuing channel
                if (ch_code == FN_RELEASE || ch_code == FN_DISCON) begin
                    conn_d = 1'b0; rsv_d = 1'b0;
                    // interrupt selections go with the release
                    eopsel_d = 1'b0; eop_d = 1'b0;
                end else if (ch_code == FN_EJECT) begin
                    post_d = LVL_EIGHT;
                end else if (ch_code > FN_POST0 && ch_code < FN_POST0 + 12'h007)
                begin
                    post_d = 4'(ch_code - FN_POST0);
                end else if (ch_code > FN_PRE0 && ch_code < FN_PRE0 + 12'h007)
                begin
                    pre_d = 4'(ch_code - FN_PRE0);
                end else if (ch_code == FN_INT_EOP) begin
                    eopsel_d = 1'b1;
                end else if (ch_code == FN_INT_CLR) begin
                    eopsel_d = 1'b0; eop_d = 1'b0;
                end else begin
                    rep_d = 1'b0;
                    rej_d = 1'b1;
                end
            end
        end
        // clear channel: drop link if this channel holds it, clear function logic and parity flag, hold off codes
        if (ch_clear) begin
            if (cch_q == ch_id) begin
                conn_d = 1'b0; rsv_d = 1'b0;
            end
            tpe_d = 1'b0; eopsel_d = 1'b0; eop_d = 1'b0;
            post_d = LVL_NONE; pre_d = LVL_NONE;
            clr_d = 16'(CLR_CYCLES);
        end
        if (ch_write & ch_wr_ready & ch_par_err) begin
            tpe_d = 1'b1;
            perr_line_d = 1'b1;
        end
        if (perr_in & st_q == LPC_PRINT) perr_line_d = 1'b1;
        // low paper holds the printer after each line
        if (start_p & lph_q & ~exhaust_q) credit_d = 1'b1;
        if (~lowp) begin
            lph_d = 1'b0; exhaust_d = 1'b0;
        end
        // spacing engine: one frame per line of paper
        if (sp_q != LVL_NONE || spw_q) begin
            if (spw_q & ack_p) begin
                spw_d = 1'b0;
                frame_d = frame_q + 8'h01;
                if (holes[7] & lph_q) exhaust_d = 1'b1;
                if (sp_q == LVL_NONE || hole_at(holes, sp_q))
                    sp_d = LVL_NONE;
                else
                    sp_d = sp_q;
            end else if (~spw_q) begin
                spw_d = 1'b1; step_d = 1'b1;
                if (sp_q == 4'hF) sp_d = LVL_NONE;
            end
        end
        case (st_q)
            LPC_IDLE: begin
                if (space_p & ~spw_q & sp_q == LVL_NONE) sp_d = 4'hF;
                if (eject_p & ~spw_q & sp_q == LVL_NONE) sp_d = LVL_EIGHT;
                if (ch_write & ch_wr_ready) begin
                    eop_d = 1'b0;
                    st_d = LPC_LOAD;
                end
                if (line_end) begin
                    st_d = pre_q != LVL_NONE ? LPC_PRE : LPC_HALT;
                    if (pre_q != LVL_NONE) sp_d = pre_q;
                end
            end
            LPC_LOAD: begin
                if (line_end) begin
                    st_d = pre_q != LVL_NONE ? LPC_PRE : LPC_HALT;
                    sp_d = pre_q;
                end
            end
            LPC_PRE: begin
                // paper moves before the line prints
                if (sp_q == LVL_NONE & ~spw_q) st_d = LPC_HALT;
            end
            LPC_HALT: begin
                // override decides whether a bad line prints
                if (perr_line_q & ~(gen_ovr_fit ? err_ovr : par_ovr)) begin
                    if (start_p & stop_seen_q) perr_line_d = 1'b0;
                end else if (~stopping | credit_q) begin
                    credit_d = 1'b0;
                    go_d = 1'b1;
                    st_d = LPC_PRINT;
                end
            end
            LPC_PRINT: begin
                // the line finishes whatever clears arrive
                if (done_p) begin
                    sp_d = post_q != LVL_NONE ? post_q : 4'hF;
                    st_d = LPC_POST;
                end
            end
            LPC_POST: begin
                // postprint motion until the selected hole
                if (sp_q == LVL_NONE & ~spw_q) begin
                    // end of operation raised per line
                    // a release in this very cycle already wins
                    if (eopsel_d) eop_d = 1'b1;
                    if (lowp) lph_d = 1'b1;
                    perr_line_d = 1'b0;
                    addr_d = 8'h00;
                    st_d = LPC_IDLE;
                end
            end
            default: st_d = LPC_IDLE;
        endcase
        if (ch_write & ch_wr_ready) begin
            we_d = 1'b1;
            dat_d = ch_code;
            addr_d = addr_q + 8'h01;
            if (st_q == LPC_IDLE) addr_d = 8'h01;
        end
        // external clear resets logic but spares a printing line
        if (mclr) begin
            conn_d = 1'b0; rsv_d = 1'b0; tpe_d = 1'b0; eopsel_d = 1'b0;
            eop_d = 1'b0; post_d = LVL_NONE; pre_d = LVL_NONE;
            online_d = 1'b0; perr_line_d = 1'b0;
            if (st_q != LPC_PRINT) begin
                st_d = LPC_IDLE; addr_d = 8'h00;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= LPC_IDLE; conn_q <= 1'b0; rsv_q <= 1'b0;
            cch_q <= 1'b0; tpe_q <= 1'b0; stop_seen_q <= 1'b0;
            online_q <= 1'b0; lph_q <= 1'b0; credit_q <= 1'b0;
            exhaust_q <= 1'b0; eopsel_q <= 1'b0; eop_q <= 1'b0;
            perr_line_q <= 1'b0; post_q <= LVL_NONE; pre_q <= LVL_NONE;
            sp_q <= LVL_NONE; spw_q <= 1'b0; step_q <= 1'b0;
            go_q <= 1'b0; frame_q <= 8'h00; addr_q <= 8'h00;
            we_q <= 1'b0; rep_q <= 1'b0; rej_q <= 1'b0; pe_q <= 1'b0;
            dat_q <= 12'h000; clr_q <= 16'h0000;
        end else begin
            st_q <= st_d; conn_q <= conn_d; rsv_q <= rsv_d;
            cch_q <= cch_d; tpe_q <= tpe_d; stop_seen_q <= stop_seen_d;
            online_q <= online_d; lph_q <= lph_d; credit_q <= credit_d;
            exhaust_q <= exhaust_d; eopsel_q <= eopsel_d; eop_q <= eop_d;
            perr_line_q <= perr_line_d; post_q <= post_d; pre_q <= pre_d;
            sp_q <= sp_d; spw_q <= spw_d; step_q <= step_d;
            go_q <= go_d; frame_q <= frame_d; addr_q <= addr_d;
            we_q <= we_d; rep_q <= rep_d; rej_q <= rej_d; pe_q <= pe_d;
            dat_q <= dat_d; clr_q <= clr_d;
        end
    end

    // indications come straight from state flops; ready gates online_q with lph_q
    assign connected  = conn_q;
    assign reserved   = rsv_q;
    assign conn_chan  = cch_q;
    assign ready      = online_q & ~lph_q;
    assign tpe_lamp   = tpe_q;
    assign ch_reply   = rep_q;
    assign ch_reject  = rej_q;
    assign ch_perr    = pe_q;
    assign pm_we      = we_q;
    assign pm_addr    = addr_q;
    assign pm_data    = dat_q;
    assign prt_go     = go_q;
    assign paper_step = step_q;
    // interrupt on the line picked by the equipment switch
    assign irq = (eop_q & ~irq_off) ? (8'h01 << eq_n) : 8'h00;

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == OFS_STATUS)
            prdata = {21'h000000, st_q, 2'h0, lph_q, cch_q, tpe_q,
                      ready, rsv_q, conn_q};
        else if (paddr == OFS_CTRL)
            prdata = {30'h00000000, ctrl_q};
        else if (paddr == OFS_FRAME)
            prdata = {16'h0000, addr_q, frame_q};
    end

    // a release from a foreign channel changes nothing
    a_release_own: assert property (@(posedge mclk) disable iff (!resetn)
        ch_function & ~own & ~ch_clear & ~ext_mclr & ~ch_connect
        |=> $stable(conn_q) && $stable(rsv_q))
        else $error("foreign function changed link");
    // clear channel drops own link next cycle
    a_clear_drops: assert property (@(posedge mclk) disable iff (!resetn)
        ch_clear & (cch_q == ch_id) |=> !conn_q && !rsv_q)
        else $error("clear channel kept link");
    // parity error on a function lights the lamp
    a_tpe_set: assert property (@(posedge mclk) disable iff (!resetn)
        ch_function & own & ch_par_err & ~busy_clr |=> tpe_q && ch_perr)
        else $error("parity flag not set");
    // nothing accepted when stopped and idle
    a_stop_refuse: assert property (@(posedge mclk) disable iff (!resetn)
        st_q == LPC_IDLE & ~ready |-> !ch_wr_ready)
        else $error("write accepted while stopped");
    // a printing line survives external clear
    a_print_holds: assert property (@(posedge mclk) disable iff (!resetn)
        st_q == LPC_PRINT & ~done_p |=> st_q == LPC_PRINT)
        else $error("printing line abandoned");
    // every step acknowledged advances the frame
    a_frame_step: assert property (@(posedge mclk) disable iff (!resetn)
        spw_q & ack_p |=> frame_q == $past(frame_q) + 8'h01)
        else $error("frame did not advance");
    // irq only on the equipment line
    a_irq_line: assert property (@(posedge mclk) disable iff (!resetn)
        irq != 8'h00 |-> irq == (8'h01 << eq_n) && eop_q)
        else $error("irq on wrong line");
    // bad line without parity override never prints, general override not fitted
    a_par_halt: assert property (@(posedge mclk) disable iff (!resetn)
        st_q == LPC_HALT & perr_line_q & ~gen_ovr_fit & ~par_ovr
        |=> !prt_go)
        else $error("bad line printed");
    // clear holds off codes for at least the next two cycles
    a_clr_busy: assert property (@(posedge mclk) disable iff (!resetn)
        ch_clear |=> busy_clr [*2])
        else $error("clear time too short");
    c_line_done: cover property (@(posedge mclk) disable iff (!resetn)
        st_q == LPC_POST ##1 st_q == LPC_IDLE);
    c_connect: cover property (@(posedge mclk) disable iff (!resetn)
        ch_connect ##1 ch_reply);
    c_lowpaper: cover property (@(posedge mclk) disable iff (!resetn)
        lph_q & credit_q);
endmodule

//--- dv/lpc_chan_model.sv
// lpc_chan_model: data channel issuing connect, function, clear, write.
// assumes tasks are entered just after a rising mclk edge.
module lpc_chan_model (
    input  wire logic        mclk,
    input  wire logic        ch_wr_ready,
    output logic             ch_id,
    output logic             ch_connect,
    output logic             ch_function,
    output logic             ch_clear,
    output logic             ch_write,
    output logic             ch_last,
    output logic             ch_par_err,
    output logic [11:0]      ch_code
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {ch_id, ch_connect, ch_function, ch_clear} = '0;
        {ch_write, ch_last, ch_par_err} = '0;
        ch_code = 12'h5A5;
    end
    // one-cycle connect, function or clear strobe from channel id; k picks which
    task automatic strobe(input int k, input logic id,
                          input logic [11:0] c, input logic pe);
        ch_id       <= id;
        ch_code     <= c;
        ch_par_err  <= pe;
        ch_connect  <= (k == 0);
        ch_function <= (k == 1);
        ch_clear    <= (k == 2);
        @(posedge mclk);
        {ch_connect, ch_function, ch_clear, ch_par_err} <= '0;
        ch_code <= ~c;
    endtask
    // next line loaded promptly, held until ready
    task automatic write(input logic [11:0] c, input logic l,
                         input logic pe);
        ch_write   <= 1'b1;
        ch_code    <= c;
        ch_last    <= l;
        ch_par_err <= pe;
        do @(posedge mclk); while (ch_wr_ready !== 1'b1);
        // strobe stays up between chars of a line, drops after the last
        if (l) begin
            {ch_write, ch_last, ch_par_err} <= '0;
            ch_code <= ~c;
        end
    endtask
endmodule

//--- dv/testbench.sv
// testbench: self-checking run of lpc_ctrl against a channel model.
// assumes 100 MHz mclk; the printer answers each pulse a cycle later.
module testbench;
    import lpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, irq, tape_hole, pm_addr, tape_pos, np, pa;
    logic [11:0] pd;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] ch_code, pm_data;
    logic        ch_id, ch_connect, ch_function, ch_clear, ch_write;
    logic        ch_last, ch_par_err, ext_mclr, ch_reply, ch_reject;
    logic        ch_perr, ch_wr_ready, connected, reserved, conn_chan;
    logic        ready, tpe_lamp, sw_start, sw_stop, sw_space, sw_eject;
    logic        sw_par_ovr, sw_err_ovr, low_paper, print_err, prt_done;
    logic        step_ack, pm_we, prt_go, paper_step;
    logic [2:0]  eq_sw;
    int          n_fail, tests_run;

    lpc_ctrl #(.CLR_CYCLES(8)) dut (
        .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ch_id, .ch_connect, .ch_function,
        .ch_clear, .ch_write, .ch_last, .ch_par_err, .ch_code, .ext_mclr,
        .ch_reply, .ch_reject, .ch_perr, .ch_wr_ready, .irq, .connected,
        .reserved, .conn_chan, .ready, .tpe_lamp, .eq_sw, .sw_start,
        .sw_stop, .sw_space, .sw_eject, .sw_par_ovr, .sw_err_ovr,
        .low_paper, .print_err, .prt_done, .step_ack, .tape_hole, .pm_we,
        .pm_addr, .pm_data, .prt_go, .paper_step);
    lpc_chan_model chan (
        .mclk, .ch_wr_ready, .ch_id, .ch_connect, .ch_function, .ch_clear,
        .ch_write, .ch_last, .ch_par_err, .ch_code);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // tape: level 4 hole every fourth frame, level 8 every 32nd
    assign np = tape_pos + 8'(paper_step);
    always @(posedge mclk) begin
        prt_done  <= prt_go;
        step_ack  <= paper_step;
        tape_pos  <= np;
        tape_hole <= {np[4:0] == 5'h00, 3'h0, np[1:0] == 2'h0, 3'h0};
        if (pm_we) {pa, pd} <= {pm_addr, pm_data};
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic ans(input logic [2:0] e);
        @(negedge mclk);
        chk("answer", e, {ch_reply, ch_reject, ch_perr});
        @(posedge mclk);
    endtask
    task automatic press(input logic [2:0] m);
        {sw_start, sw_stop, sw_space} <= m;
        repeat (5) @(posedge mclk);
        {sw_start, sw_stop, sw_space} <= 3'b000;
        repeat (5) @(posedge mclk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        conclude();
    end
    initial begin
        {resetn, psel, penable, pwrite, ext_mclr, sw_start} = '0;
        {sw_stop, sw_space, sw_eject, sw_par_ovr, sw_err_ovr} = '0;
        {low_paper, print_err, prt_done, step_ack} = '0;
        {paddr, pwdata, tape_pos, eq_sw} = {8'h00, 32'h0, 8'h00, 3'h5};
        {n_fail, tests_run} = '0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk("idle", 32'h0, {irq, connected, reserved, ready});
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        $display("test registers finished");
        chan.strobe(0, 1'b0, 12'h200, 1'b0);
        ans(3'b000);
        chan.strobe(0, 1'b0, 12'hA00, 1'b0);
        ans(3'b100);
        chk("link", 32'h3, {connected, reserved});
        press(3'b100);
        chk("ready", 32'h1, ready);
        $display("test connect finished");
        chan.strobe(1, 1'b0, FN_INT_EOP, 1'b0);
        ans(3'b100);
        sw_par_ovr <= 1'b1;
        repeat (4) @(posedge mclk);
        chan.write(12'h101, 1'b0, 1'b1);
        chan.write(12'h202, 1'b0, 1'b0);
        chan.write(12'h303, 1'b1, 1'b0);
        for (int i = 0; i < 300 && irq[5] !== 1'b1; i++)
            @(posedge mclk);
        chk("irq", 32'h20, irq);
        apb(1'b0, OFS_FRAME, 32'h0);
        chk("frame", 32'h1, rd[7:0]);
        press(3'b001);
        repeat (10) @(posedge mclk);
        apb(1'b0, OFS_FRAME, 32'h0);
        chk("frame", 32'h2, rd[7:0]);
        press(3'b010);
        chk("stop", 32'h1, {ready, ch_wr_ready, tpe_lamp});
        chan.strobe(1, 1'b0, FN_RELEASE, 1'b0);
        ans(3'b100);
        chk("release", 32'h0, {irq, connected, reserved});
        press(3'b100);
        chk("start", 32'h2, {ready, tpe_lamp});
        $display("test line finished");
        chan.strobe(0, 1'b0, 12'hA00, 1'b0);
        ans(3'b100);
        chan.strobe(1, 1'b0, FN_INT_EOP, 1'b1);
        ans(3'b001);
        chk("perr", 32'h1, tpe_lamp);
        chan.strobe(2, 1'b0, 12'h000, 1'b0);
        repeat (12) @(posedge mclk);
        chk("clear", 32'h0, {connected, reserved, tpe_lamp});
        chan.strobe(0, 1'b1, 12'hA00, 1'b0);
        ans(3'b100);
        chk("chan", 32'h1, conn_chan);
        ext_mclr <= 1'b1;
        repeat (2) @(posedge mclk);
        ext_mclr <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("mclr", 32'h0, {connected, reserved});
        $display("test clears finished");
        chan.strobe(0, 1'b0, 12'hA00, 1'b0);
        ans(3'b100);
        press(3'b100);
        chan.strobe(1, 1'b0, FN_POST0 + 12'h004, 1'b0);
        ans(3'b100);
        chan.strobe(1, 1'b0, 12'h07F, 1'b0);
        ans(3'b010);
        chan.write(12'h444, 1'b1, 1'b0);
        repeat (60) @(posedge mclk);
        chk("pmem", 32'h1444, {pa, pd});
        apb(1'b0, OFS_FRAME, 32'h0);
        chk("level", 32'h4, rd[7:0]);
        sw_par_ovr <= 1'b0;
        repeat (4) @(posedge mclk);
        chan.write(12'h555, 1'b1, 1'b1);
        repeat (60) @(posedge mclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("halt", 32'h7, rd[10:8]);
        press(3'b010);
        press(3'b100);
        repeat (60) @(posedge mclk);
        apb(1'b0, OFS_FRAME, 32'h0);
        chk("resume", 32'h8, rd[7:0]);
        $display("test format finished");
        conclude();
    end
endmodule
